// >>> rtl/irq_flag_enable_bank.sv
// interrupt flag and enable bank with reset-cause and oscillator registers, AXI4-Lite slave
// ==========================================================
// Overview of operation
// - device reset loads control registers to defined values
// - flag, enable and mask reset values same for any reset source
// - reset cause register reflects reset kind
// - oscillator register from reset kind and configuration
// - flag reads one after request, software writable
// - enable bit passes or blocks its request
// - bit 13 is DMA channel 5 done
// - bit 12 is codec interface event
// - bit 11 is codec interface error
// - bit 8 is second CAN general event
// - bit 7 is second CAN receive ready
// - bits 6,5 are external pins four, three
// - bits 4..0 timers, second I2C flags
// - unimplemented flag bits ignore writes, read zero
// ==========================================================
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
module irq_flag_enable_bank
    import irq_flag_enable_pkg::*;
#(
    parameter int ADDR_W = 8 // byte address width of the slave
) (
    input wire logic sys_clk_i, // system clock, 40 MHz
    input wire logic rst_n_i, // async reset, active low
    input wire reset_kind_e reset_kind_i, // kind of the reset being released
    input wire logic [2:0] oscillator_config_word_i, // programmed oscillator source
    input wire flag_events_s events_i, // one-cycle source event pulses
    input wire logic [15:0] group_req_i, // request levels of the enable group
    output logic [15:0] group_irq_o, // group requests after enable gating
    output logic irq_o, // level interrupt, unmasked flag set
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte lanes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready // read data ready
);

    // the map needs the offsets up to OSC_OFF to be addressable
    // checked at elaboration, so a bad width never reaches simulation
    if (ADDR_W < 5 || ADDR_W > 32) begin : addr_w_check
        $error("ADDR_W must lie between 5 and 32");
    end

    // ==========================================================
    // state
    // ==========================================================
    logic [15:0] flag3_r; // interrupt_flag_status_3
    logic [15:0] flag3_nxt; // its next value
    logic [15:0] group_en_r; // interrupt_enable_uart_timer_group
    logic [15:0] mask3_r; // flag gate onto irq_o
    logic [15:0] cause_r; // reset_cause_control_reg
    logic [15:0] osc_r; // oscillator_control_reg
    logic load_done_r; // reset-dependent values captured
    logic have_aw_r; // write address held
    logic have_w_r; // write data held
    logic [ADDR_W-1:0] aw_addr_r; // held write address
    logic [15:0] w_data_r; // held write data, low half
    logic [1:0] w_strb_r; // held byte lanes, low half
    logic [15:0] ev_vec; // events placed at their flag bits
    logic [15:0] be; // bit enables from byte lanes
    logic wr_go; // write commits this cycle
    logic wr_flag, wr_en, wr_mask, wr_clr, wr_cause, wr_osc, wr_err; // write decode
    logic [15:0] rd_val; // read mux result
    logic rd_err; // read of an unmapped address

    // ==========================================================
    // event placement
    // ==========================================================
    // sources land at fixed flag positions, reserved positions stay zero
    always_comb begin
        ev_vec = 16'h0000;
        ev_vec[DMA5_BIT] = events_i.dma_ch5_done_flag;
        ev_vec[CODEC_EV_BIT] = events_i.codec_if_event_flag;
        ev_vec[CODEC_ERR_BIT] = events_i.codec_if_error_flag;
        ev_vec[CAN2_EV_BIT] = events_i.can2_event_flag;
        ev_vec[CAN2_RX_BIT] = events_i.can2_rx_ready_flag;
        ev_vec[PIN4_BIT] = events_i.ext_pin4_flag;
        ev_vec[PIN3_BIT] = events_i.ext_pin3_flag;
        ev_vec[TMR9_BIT] = events_i.timer9_flag;
        ev_vec[TMR8_BIT] = events_i.timer8_flag;
        ev_vec[I2C2_M_BIT] = events_i.i2c2_master_flag;
        ev_vec[I2C2_S_BIT] = events_i.i2c2_slave_flag;
        ev_vec[TMR7_BIT] = events_i.timer7_flag;
    end

    // ==========================================================
    // write channel
    // ==========================================================
    assign be = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    assign wr_go = have_aw_r && have_w_r && !s_axi_bvalid;

    // address decode of the held write address
    always_comb begin
        wr_flag = 1'b0;
        wr_en = 1'b0;
        wr_mask = 1'b0;
        wr_clr = 1'b0;
        wr_cause = 1'b0;
        wr_osc = 1'b0;
        wr_err = 1'b0;
        if (aw_addr_r == ADDR_W'(FLAG3_OFF)) begin
            wr_flag = wr_go;
        end else if (aw_addr_r == ADDR_W'(GROUP_EN_OFF)) begin
            wr_en = wr_go;
        end else if (aw_addr_r == ADDR_W'(MASK3_OFF)) begin
            wr_mask = wr_go;
        end else if (aw_addr_r == ADDR_W'(FLAG3_CLR_OFF)) begin
            wr_clr = wr_go;
        end else if (aw_addr_r == ADDR_W'(CAUSE_OFF)) begin
            wr_cause = wr_go;
        end else if (aw_addr_r == ADDR_W'(OSC_OFF)) begin
            wr_osc = wr_go;
        end else begin
            wr_err = wr_go; // unmapped: answered with an error, nothing stored
        end
    end

    // address and data are taken in either order and held until the response
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            have_aw_r <= 1'b0;
            have_w_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= 16'h0000;
            w_strb_r <= 2'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                have_aw_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                have_w_r <= 1'b1;
                w_data_r <= s_axi_wdata[15:0];
                w_strb_r <= s_axi_wstrb[1:0];
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                have_aw_r <= 1'b0;
                have_w_r <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ==========================================================
    // flag register
    // ==========================================================
    // a source event in the same cycle as a software write or clear wins,
    // so no request is lost to a racing clear
    always_comb begin
        flag3_nxt = flag3_r;
        if (wr_flag) begin
            flag3_nxt = (flag3_r & ~be) | (w_data_r & be);
        end
        if (wr_clr) begin
            flag3_nxt = flag3_r & ~(w_data_r & be);
        end
        flag3_nxt = (flag3_nxt | ev_vec) & FLAG3_IMPL;
    end

    // flags clear on every reset kind alike
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag3_r <= FLAG3_RST;
        end else begin
            flag3_r <= flag3_nxt;
        end
    end

    // ==========================================================
    // enable and mask registers
    // ==========================================================
    // software-owned gates, cleared on every reset
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            group_en_r <= GROUP_EN_RST;
            mask3_r <= MASK3_RST;
        end else begin
            if (wr_en) begin
                group_en_r <= ((group_en_r & ~be) | (w_data_r & be)) & GROUP_EN_IMPL;
            end
            if (wr_mask) begin
                mask3_r <= ((mask3_r & ~be) | (w_data_r & be)) & FLAG3_IMPL;
            end
        end
    end

    // ==========================================================
    // reset-dependent registers
    // ==========================================================
    // an async reset may only load constants, so the reset kind and the
    // oscillator configuration are caught at the first edge after release
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            load_done_r <= 1'b0;
            cause_r <= CAUSE_RST;
            osc_r <= OSC_RST;
        end else if (!load_done_r) begin
            load_done_r <= 1'b1;
            cause_r <= 16'h0001 << reset_kind_i;
            osc_r <= OSC_RST;
            osc_r[OSC_ACT_LSB +: 3] <= oscillator_config_word_i;
            osc_r[OSC_REQ_LSB +: 3] <= oscillator_config_word_i;
            osc_r[OSC_COLD_BIT] <= (reset_kind_i == RK_POWER) || (reset_kind_i == RK_BROWNOUT);
        end else begin
            if (wr_cause) begin
                cause_r <= cause_r & ~(w_data_r & be); // cause bits are write-one-to-clear
            end
            if (wr_osc && be[OSC_REQ_LSB]) begin
                osc_r[OSC_REQ_LSB +: 3] <= w_data_r[OSC_REQ_LSB +: 3];
            end
        end
    end

    // ==========================================================
    // request outputs
    // ==========================================================
    // registered gating, one cycle behind the flag and enable state
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
            group_irq_o <= 16'h0000;
        end else begin
            irq_o <= |(flag3_r & mask3_r);
            group_irq_o <= group_req_i & group_en_r;
        end
    end

    // ==========================================================
    // read channel
    // ==========================================================
    // read decode straight from the bus address
    always_comb begin
        rd_val = 16'h0000;
        rd_err = 1'b0;
        if (s_axi_araddr == ADDR_W'(FLAG3_OFF)) begin
            rd_val = flag3_r; // reserved bits are always zero in storage
        end else if (s_axi_araddr == ADDR_W'(GROUP_EN_OFF)) begin
            rd_val = group_en_r;
        end else if (s_axi_araddr == ADDR_W'(MASK3_OFF)) begin
            rd_val = mask3_r;
        end else if (s_axi_araddr == ADDR_W'(FLAG3_CLR_OFF)) begin
            rd_val = 16'h0000; // clear port reads zero
        end else if (s_axi_araddr == ADDR_W'(CAUSE_OFF)) begin
            rd_val = cause_r;
        end else if (s_axi_araddr == ADDR_W'(OSC_OFF)) begin
            rd_val = osc_r;
        end else begin
            rd_err = 1'b1;
        end
    end

    // one read at a time, data held until taken
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rd_val};
            s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ==========================================================
    // assertions
    // ==========================================================
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence both_taken_s;
        have_aw_r && have_w_r && !s_axi_bvalid;
    endsequence

    sequence resp_up_s;
        s_axi_bvalid;
    endsequence

    flag_set_a: assert property (ev_vec[DMA5_BIT] |=> flag3_r[DMA5_BIT])
        else $error("dma channel 5 event did not set its flag");
    slave_set_a: assert property (events_i.i2c2_slave_flag |=> flag3_r[I2C2_S_BIT])
        else $error("i2c slave event did not set bit 1");
    resv_zero_a: assert property ((flag3_r & ~FLAG3_IMPL) == 16'h0000)
        else $error("unimplemented flag bit became set");
    irq_gate_a: assert property (irq_o == $past(|(flag3_r & mask3_r)))
        else $error("irq does not follow flag and mask");
    group_gate_a: assert property (##1 group_irq_o == $past(group_req_i & group_en_r))
        else $error("group request not gated by enable");
    reset_zero_a: assert property (!load_done_r |-> group_en_r == 16'h0000 && mask3_r == 16'h0000)
        else $error("enables not cleared after reset");
    cause_load_a: assert property (!load_done_r |=> cause_r == (16'h0001 << $past(reset_kind_i)))
        else $error("reset cause not loaded from reset kind");
    osc_load_a: assert property (!load_done_r
        |=> osc_r[OSC_ACT_LSB +: 3] == $past(oscillator_config_word_i))
        else $error("oscillator source not loaded from configuration");
    // an event in the cycle of a clear must survive it
    clear_race_a: assert property (wr_clr && (ev_vec != 16'h0000)
        |=> (flag3_r & $past(ev_vec)) == $past(ev_vec))
        else $error("event lost against a clear");
    // a clear with no event in flight leaves every cleared bit at zero
    clear_done_a: assert property (wr_clr && (ev_vec == 16'h0000)
        |=> (flag3_r & $past(w_data_r & be)) == 16'h0000)
        else $error("flag not cleared by a write of one");
    write_resp_a: assert property (both_taken_s |=> resp_up_s)
        else $error("write response not raised one cycle after both halves");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before ready");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before ready");

endmodule

// >>> rtl/irq_flag_enable_pkg.sv
// package for the interrupt flag and enable bank: map, layouts, reset values, types
package irq_flag_enable_pkg;

    // ==========================================================
    // register map (byte addresses, one aligned word each)
    // ==========================================================
    localparam logic [7:0] FLAG3_OFF = 8'h00;    // interrupt_flag_status_3
    localparam logic [7:0] GROUP_EN_OFF = 8'h04; // interrupt_enable_uart_timer_group
    localparam logic [7:0] MASK3_OFF = 8'h08;    // gate of flag bits onto irq_o
    localparam logic [7:0] FLAG3_CLR_OFF = 8'h0c; // write one to clear flag bits
    localparam logic [7:0] CAUSE_OFF = 8'h10;    // reset_cause_control_reg
    localparam logic [7:0] OSC_OFF = 8'h14;      // oscillator_control_reg

    // ==========================================================
    // field layouts
    // ==========================================================
    localparam logic [15:0] FLAG3_IMPL = 16'h39ff; // 15:14 and 10:9 unimplemented
    localparam logic [15:0] GROUP_EN_IMPL = 16'hfffb; // bit 2 unimplemented
    localparam int DMA5_BIT = 13;
    localparam int CODEC_EV_BIT = 12;
    localparam int CODEC_ERR_BIT = 11;
    localparam int CAN2_EV_BIT = 8;
    localparam int CAN2_RX_BIT = 7;
    localparam int PIN4_BIT = 6;
    localparam int PIN3_BIT = 5;
    localparam int TMR9_BIT = 4;
    localparam int TMR8_BIT = 3;
    localparam int I2C2_M_BIT = 2;
    localparam int I2C2_S_BIT = 1;
    localparam int TMR7_BIT = 0;
    localparam int OSC_ACT_LSB = 0;   // active source, 3 bits, read only
    localparam int OSC_COLD_BIT = 4;  // last reset was a power or brownout reset
    localparam int OSC_REQ_LSB = 8;   // requested source, 3 bits, writable

    // ==========================================================
    // reset values
    // ==========================================================
    localparam logic [15:0] FLAG3_RST = 16'h0000;
    localparam logic [15:0] GROUP_EN_RST = 16'h0000;
    localparam logic [15:0] MASK3_RST = 16'h0000;
    localparam logic [15:0] CAUSE_RST = 16'h0000;
    localparam logic [15:0] OSC_RST = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // types
    // ==========================================================
    typedef enum logic [2:0] {
        RK_POWER,
        RK_BROWNOUT,
        RK_PIN,
        RK_WATCHDOG,
        RK_SOFTWARE,
        RK_TRAP
    } reset_kind_e;

    // one-cycle event pulses from the sources of the third flag register
    typedef struct packed {
        logic dma_ch5_done_flag;
        logic codec_if_event_flag;
        logic codec_if_error_flag;
        logic can2_event_flag;
        logic can2_rx_ready_flag;
        logic ext_pin4_flag;
        logic ext_pin3_flag;
        logic timer9_flag;
        logic timer8_flag;
        logic i2c2_master_flag;
        logic i2c2_slave_flag;
        logic timer7_flag;
    } flag_events_s;

endpackage

// >>> verification/event_source_model.sv
// event source model: peripheral sources driving the flag bank's event and request inputs
module event_source_model
    import irq_flag_enable_pkg::*;
(
    input wire logic clk_i, // system clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic [11:0] fire_i, // bench command, one bit per source
    input wire logic [15:0] level_i, // bench command for group request levels
    output flag_events_s events_o, // registered one-cycle source pulses
    output logic [15:0] req_o // group request levels
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // source flops
    // ==========================================================
    // sources launch from their own flops, so pulses never change on the sampling edge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            events_o <= '0; // sources are quiet in reset
            req_o <= '0;
        end else begin
            events_o <= fire_i; // one pulse per command cycle
            req_o <= level_i; // requests are plain levels
        end
    end
endmodule

// >>> verification/irq_flag_enable_bank_test.sv
// self-checking bench for the interrupt flag and enable bank
module irq_flag_enable_bank_test;
    import irq_flag_enable_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // stimulus and observation signals
    // ==========================================================
    logic sys_clk_i = 1'b0; // 40 MHz system clock
    logic rst_n_i = 1'b0; // reset, active low
    reset_kind_e kind = RK_POWER; // kind of the reset being released
    logic [2:0] cfg = 3'h0; // programmed oscillator source
    logic [11:0] fire = 12'h000; // event commands to the model
    logic [15:0] level = 16'h0000; // group request commands
    flag_events_s events; // model pulses into the bank
    logic [15:0] req, group_irq; // group levels in and out
    logic irq; // level interrupt
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int bad_count = 0; // mismatches seen
    int total_checks = 0; // comparisons made
    logic [31:0] rd; // last read word
    logic [1:0] rs; // last response
    always #12.5 sys_clk_i = ~sys_clk_i;
    // ==========================================================
    // design and partner
    // ==========================================================
    irq_flag_enable_bank dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reset_kind_i(kind),
        .oscillator_config_word_i(cfg), .events_i(events), .group_req_i(req), .group_irq_o(group_irq),
        .irq_o(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    event_source_model src (.clk_i(sys_clk_i), .rst_n_i(rst_n_i), .fire_i(fire), .level_i(level),
        .events_o(events), .req_o(req));
    // ==========================================================
    // reporting
    // ==========================================================
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // compare one value; case inequality so an unknown never matches
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic hang(input string what);
        bad_count++;
        $display("[FAIL] %s expected handshake seen none", what);
        tally_and_finish();
    endtask
    // ==========================================================
    // bus tasks
    // ==========================================================
    // address and data offered together, each released when taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        bit done;
        n = 0;
        done = 1'b0;
        @(posedge sys_clk_i); // an edge between transfers, no double drive
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge sys_clk_i);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                r = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end else if (n > 50) begin
                hang("write response");
            end
        end
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        bit done;
        n = 0;
        done = 1'b0;
        @(posedge sys_clk_i); // an edge between transfers, no double drive
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge sys_clk_i);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end else if (n > 50) begin
                hang("read data");
            end
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axi_write(a, d, rs);
        check("write response", {30'h0, RESP_OKAY}, {30'h0, rs});
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        axi_read(a, rd, rs);
        check(what, exp, rd);
    endtask
    // reset held four cycles; kind and configuration stay stable across the release
    task automatic do_reset(input reset_kind_e k, input logic [2:0] c);
        rst_n_i <= 1'b0;
        kind <= k;
        cfg <= c;
        repeat (4) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
    endtask
    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        logic [15:0] cold;
        int pos; // flag position of source k
        // every reset kind: cause, oscillator and plain registers
        for (int k = 0; k < 6; k++) begin
            do_reset(reset_kind_e'(k), 3'(k + 1));
            cold = (k <= 1) ? 16'h1 : 16'h0;
            rd_chk("cause", CAUSE_OFF, 32'(16'h1 << k));
            rd_chk("osc", OSC_OFF, 32'((16'(k + 1) << OSC_ACT_LSB) | (cold << OSC_COLD_BIT)
                | (16'(k + 1) << OSC_REQ_LSB)));
            rd_chk("flag reset", FLAG3_OFF, 32'h0);
            rd_chk("enable reset", GROUP_EN_OFF, 32'h0);
            rd_chk("mask reset", MASK3_OFF, 32'h0);
        end
        wr(CAUSE_OFF, 32'h0000ffff);
        rd_chk("cause clear", CAUSE_OFF, 32'h0);
        wr(OSC_OFF, 32'h00000700);
        rd_chk("osc request", OSC_OFF, 32'h00000706);
        $display("test reset_values done");
        // each source sets only its own bit
        for (int k = 0; k < 12; k++) begin
            fire <= 12'(1 << k);
            @(posedge sys_clk_i);
            fire <= 12'h000;
            repeat (3) @(posedge sys_clk_i);
            pos = (k < 9) ? k : k + 2; // sources skip reserved bits 10:9
            rd_chk("map", FLAG3_OFF, 32'h1 << pos);
            wr(FLAG3_CLR_OFF, 32'h0000ffff);
            rd_chk("flag cleared", FLAG3_OFF, 32'h0);
        end
        $display("test event_map done");
        // software writes; reserved positions stay zero
        wr(FLAG3_OFF, 32'hffffffff);
        rd_chk("flag write", FLAG3_OFF, 32'(FLAG3_IMPL));
        wr(FLAG3_OFF, 32'h0);
        rd_chk("flag zero", FLAG3_OFF, 32'h0);
        $display("test flag_write done");
        // interrupt only where flag and its gate are both set
        wr(MASK3_OFF, 32'h00002000);
        wr(FLAG3_OFF, 32'h00001000);
        repeat (3) @(posedge sys_clk_i);
        check("irq masked", 32'h0, {31'h0, irq});
        fire <= 12'h800;
        @(posedge sys_clk_i);
        fire <= 12'h000;
        repeat (3) @(posedge sys_clk_i);
        check("irq raised", 32'h1, {31'h0, irq});
        wr(FLAG3_CLR_OFF, 32'h00002000);
        repeat (3) @(posedge sys_clk_i);
        check("irq cleared", 32'h0, {31'h0, irq});
        // an event landing in the commit cycle of a clear keeps its flag
        fork
            wr(FLAG3_CLR_OFF, 32'h0000ffff);
            begin
                @(posedge sys_clk_i);
                fire <= 12'h800;
                @(posedge sys_clk_i);
                fire <= 12'h000;
            end
        join
        rd_chk("set beats clear", FLAG3_OFF, 32'h00002000);
        $display("test irq_gate done");
        // enable register passes or blocks each request
        level <= 16'hffff;
        repeat (4) @(posedge sys_clk_i);
        check("group blocked", 32'h0, {16'h0, group_irq});
        wr(GROUP_EN_OFF, 32'hffffffff);
        rd_chk("enable write", GROUP_EN_OFF, 32'(GROUP_EN_IMPL));
        repeat (3) @(posedge sys_clk_i);
        check("group passed", 32'(GROUP_EN_IMPL), {16'h0, group_irq});
        level <= 16'h0000;
        $display("test group_enable done");
        // unmapped place answers a write and a read with an error
        axi_write(8'h20, 32'hffffffff, rs);
        check("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, rs});
        axi_read(8'h20, rd, rs);
        check("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, rs});
        $display("test unmapped done");
        tally_and_finish();
    end
endmodule
